//--- rtl/qa_watchdog_answer_check.sv
// Question-and-answer watchdog answer checker with APB register port.
// Assumes an external window timer supplies the window phase and a
// time-out pulse, and restarts its windows on sequence_start_out.
//
// Function
// - First reply bytes per question are tabulated.
// - Good sequence decrements fail count, advances question.
// - Correct but early: increment, set early flag.
// - Wrong, in close window: increment, set error.
// - Wrong and early: increment, set both flags.
// - Time-out increments fail count, sets time-out flag.
// - Window duration write increments, sets config flag.
// - After time-out, error flag shows earlier mismatches.
// - Config change shows only config flag; good clears.
// - Reply index starts at 3, counts down, reloads.
// - Question from counter and Markov chain; advance good.
// - Duration write starts new sequence even when locked.
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module qa_watchdog_answer_check
    import qa_watchdog_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic [31:0] prdata_out,
    output logic pslverr_out,
    // Window timer side
    input wire logic close_window_in,
    input wire logic timeout_in,
    input wire logic config_lock_in,
    output logic sequence_start_out,
    output logic [2:0] fail_count_out,
    output logic irq_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [1:0] reply_index_counter;
        logic answer_err;
        logic window_config_changed_flag;
        logic sequence_error_flag;
        logic time_out_flag;
        logic answer_early_flag;
        logic [2:0] sequence_fail_counter;
        logic [7:0] open_window_duration;
        logic [7:0] close_window_duration;
        logic [1:0] question_feedback_select;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
        logic irq;
        logic seq_start;
        logic advance;
    } wd_state_t;

    wd_state_t state_reg;
    wd_state_t state_next;

    logic rstn_sync;
    logic [3:0] question;
    logic [7:0] reference_byte;

    // ------------------------------------------------------------
    // Reset release and reference generation
    // ------------------------------------------------------------
    qa_reset_sync u_reset_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .rstn_sync_out(rstn_sync)
    );

    qa_reference_gen u_reference_gen (
        .clk_in(clk_in),
        .rstn_in(rstn_sync),
        .advance_in(state_reg.advance),
        .reply_index_in(state_reg.reply_index_counter),
        .question_out(question),
        .reference_byte_out(reference_byte)
    );

    // ------------------------------------------------------------
    // Bus decode helpers
    // ------------------------------------------------------------
    logic access_start;
    logic commit;
    logic write_commit;
    logic addr_mapped;
    logic reply_write;
    logic config_write;
    logic irq_clear_write;
    logic [31:0] status_word;
    logic [31:0] read_word;

    // Access phase answers one cycle after it opens
    assign access_start = psel_in & penable_in & ~state_reg.pready;
    assign commit = psel_in & penable_in & state_reg.pready;
    assign write_commit = commit & pwrite_in;

    always_comb begin
        addr_mapped = 1'b1;
        if (paddr_in == ADDR_QUESTION_VALUE) begin
            addr_mapped = 1'b1;
        end else if (paddr_in == ADDR_REPLY_BYTE) begin
            addr_mapped = 1'b1;
        end else if (paddr_in == ADDR_WATCHDOG_STATUS) begin
            addr_mapped = 1'b1;
        end else if (paddr_in == ADDR_OPEN_WINDOW) begin
            addr_mapped = 1'b1;
        end else if (paddr_in == ADDR_CLOSE_WINDOW) begin
            addr_mapped = 1'b1;
        end else if (paddr_in == ADDR_IRQ_STATUS) begin
            addr_mapped = 1'b1;
        end else if (paddr_in == ADDR_IRQ_MASK) begin
            addr_mapped = 1'b1;
        end else if (paddr_in == ADDR_FEEDBACK_SELECT) begin
            addr_mapped = 1'b1;
        end else begin
            addr_mapped = 1'b0;
        end
    end

    assign reply_write = write_commit & (paddr_in == ADDR_REPLY_BYTE);
    assign config_write = write_commit & ((paddr_in == ADDR_OPEN_WINDOW) | (paddr_in == ADDR_CLOSE_WINDOW));
    assign irq_clear_write = write_commit & (paddr_in == ADDR_IRQ_STATUS);

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[STAT_CFG_CHG_BIT] = state_reg.window_config_changed_flag;
        status_word[STAT_SEQ_BAD_BIT] = state_reg.sequence_error_flag;
        status_word[STAT_TIME_OUT_BIT] = state_reg.time_out_flag;
        status_word[STAT_EARLY_BIT] = state_reg.answer_early_flag;
        status_word[STAT_ANSWER_ERR_BIT] = state_reg.answer_err;
        status_word[STAT_INDEX_LSB +: 2] = state_reg.reply_index_counter;
        status_word[STAT_FAIL_LSB +: 3] = state_reg.sequence_fail_counter;
    end

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    always_comb begin
        read_word = 32'h0000_0000;
        if (paddr_in == ADDR_QUESTION_VALUE) begin
            read_word[3:0] = question;
        end else if (paddr_in == ADDR_WATCHDOG_STATUS) begin
            read_word = status_word;
        end else if (paddr_in == ADDR_OPEN_WINDOW) begin
            read_word[7:0] = state_reg.open_window_duration;
        end else if (paddr_in == ADDR_CLOSE_WINDOW) begin
            read_word[7:0] = state_reg.close_window_duration;
        end else if (paddr_in == ADDR_IRQ_STATUS) begin
            read_word[3:0] = state_reg.irq_status;
        end else if (paddr_in == ADDR_IRQ_MASK) begin
            read_word[3:0] = state_reg.irq_mask;
        end else if (paddr_in == ADDR_FEEDBACK_SELECT) begin
            read_word[1:0] = state_reg.question_feedback_select;
        end else begin
            // Reply byte register is write-only and reads zero
            read_word = 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Sequence evaluation
    // ------------------------------------------------------------
    logic byte_mismatch;
    logic final_byte;
    logic seq_failed_value;
    logic good_event;
    logic bad_event;
    logic timeout_event;
    logic [3:0] irq_events;
    logic [2:0] fail_inc;
    logic [2:0] fail_dec;

    assign byte_mismatch = pwdata_in[7:0] != reference_byte;
    assign final_byte = state_reg.reply_index_counter == 2'h0;
    assign seq_failed_value = state_reg.answer_err | byte_mismatch;

    // Priority: duration write, then time-out, then the final reply byte
    assign timeout_event = timeout_in & ~config_write;
    assign good_event = reply_write & final_byte & ~config_write & ~timeout_in & ~seq_failed_value & close_window_in;
    assign bad_event = reply_write & final_byte & ~config_write & ~timeout_in & ~good_event;

    // Counter saturates at both ends rather than wrapping
    assign fail_inc = (state_reg.sequence_fail_counter == FAIL_COUNT_MAX) ? FAIL_COUNT_MAX
                      : state_reg.sequence_fail_counter + 3'h1;
    assign fail_dec = (state_reg.sequence_fail_counter == FAIL_COUNT_RESET) ? FAIL_COUNT_RESET
                      : state_reg.sequence_fail_counter - 3'h1;

    always_comb begin
        irq_events = 4'h0;
        irq_events[EVT_GOOD_BIT] = good_event;
        irq_events[EVT_BAD_BIT] = bad_event;
        irq_events[EVT_TIMEOUT_BIT] = timeout_event;
        irq_events[EVT_CFG_BIT] = config_write;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.seq_start = 1'b0;
        state_next.advance = 1'b0;

        // Bus handshake
        state_next.pready = access_start;
        if (access_start) begin
            state_next.prdata = read_word;
            state_next.pslverr = ~addr_mapped;
        end else if (commit) begin
            state_next.prdata = 32'h0000_0000;
            state_next.pslverr = 1'b0;
        end

        // Software-held registers
        if (write_commit) begin
            if (paddr_in == ADDR_OPEN_WINDOW) begin
                if (!config_lock_in) begin
                    state_next.open_window_duration = pwdata_in[7:0];
                end
            end else if (paddr_in == ADDR_CLOSE_WINDOW) begin
                if (!config_lock_in) begin
                    state_next.close_window_duration = pwdata_in[7:0];
                end
            end else if (paddr_in == ADDR_IRQ_MASK) begin
                state_next.irq_mask = pwdata_in[3:0];
            end else if (paddr_in == ADDR_FEEDBACK_SELECT) begin
                state_next.question_feedback_select = pwdata_in[1:0];
            end
        end

        // Watchdog sequence
        if (config_write) begin
            // Locked registers still restart the sequence
            state_next.sequence_fail_counter = fail_inc;
            state_next.window_config_changed_flag = 1'b1;
            state_next.sequence_error_flag = 1'b0;
            state_next.time_out_flag = 1'b0;
            state_next.answer_early_flag = 1'b0;
            state_next.reply_index_counter = REPLY_INDEX_START;
            state_next.answer_err = 1'b0;
            state_next.seq_start = 1'b1;
        end else if (timeout_in) begin
            state_next.sequence_fail_counter = fail_inc;
            state_next.time_out_flag = 1'b1;
            state_next.sequence_error_flag = state_reg.answer_err;
            state_next.answer_early_flag = 1'b0;
            state_next.window_config_changed_flag = 1'b0;
            state_next.reply_index_counter = REPLY_INDEX_START;
            state_next.answer_err = 1'b0;
            state_next.seq_start = 1'b1;
        end else if (reply_write) begin
            if (final_byte) begin
                state_next.reply_index_counter = REPLY_INDEX_START;
                state_next.answer_err = 1'b0;
                state_next.seq_start = 1'b1;
                state_next.window_config_changed_flag = 1'b0;
                state_next.time_out_flag = 1'b0;
                if (good_event) begin
                    state_next.sequence_fail_counter = fail_dec;
                    state_next.advance = 1'b1;
                    state_next.sequence_error_flag = 1'b0;
                    state_next.answer_early_flag = 1'b0;
                end else begin
                    state_next.sequence_fail_counter = fail_inc;
                    // Correct-but-early leaves the error flag clear
                    state_next.sequence_error_flag = seq_failed_value;
                    state_next.answer_early_flag = ~close_window_in;
                end
            end else begin
                // Early bytes may land in either window
                state_next.reply_index_counter = state_reg.reply_index_counter - 2'h1;
                state_next.answer_err = seq_failed_value;
            end
        end

        // Interrupts: a new event beats a clear in the same cycle
        if (irq_clear_write) begin
            state_next.irq_status = (state_reg.irq_status & ~pwdata_in[3:0]) | irq_events;
        end else begin
            state_next.irq_status = state_reg.irq_status | irq_events;
        end
        state_next.irq = |(state_reg.irq_status & state_reg.irq_mask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_sync) begin
        if (!rstn_sync) begin
            state_reg <= '0;
            state_reg.reply_index_counter <= REPLY_INDEX_START;
            state_reg.sequence_fail_counter <= FAIL_COUNT_RESET;
            state_reg.open_window_duration <= WINDOW_DURATION_RESET;
            state_reg.close_window_duration <= WINDOW_DURATION_RESET;
            state_reg.question_feedback_select <= FEEDBACK_RESET;
            state_reg.irq_mask <= IRQ_MASK_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pready_out = state_reg.pready;
    assign prdata_out = state_reg.prdata;
    assign pslverr_out = state_reg.pslverr;
    assign sequence_start_out = state_reg.seq_start;
    assign fail_count_out = state_reg.sequence_fail_counter;
    assign irq_out = state_reg.irq;

endmodule : qa_watchdog_answer_check

`default_nettype wire

//--- rtl/qa_watchdog_pkg.sv
// Package for the question-and-answer watchdog answer checker.
// Assumes one 40 MHz system clock and a 32-bit APB register port.

package qa_watchdog_pkg;

    // ------------------------------------------------------------
    // Clock
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 25;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_QUESTION_VALUE = 8'h00;
    localparam logic [7:0] ADDR_REPLY_BYTE = 8'h04;
    localparam logic [7:0] ADDR_WATCHDOG_STATUS = 8'h08;
    localparam logic [7:0] ADDR_OPEN_WINDOW = 8'h0C;
    localparam logic [7:0] ADDR_CLOSE_WINDOW = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    localparam logic [7:0] ADDR_FEEDBACK_SELECT = 8'h1C;

    // ------------------------------------------------------------
    // Status register field positions
    // ------------------------------------------------------------
    localparam int unsigned STAT_CFG_CHG_BIT = 0;
    localparam int unsigned STAT_SEQ_BAD_BIT = 1;
    localparam int unsigned STAT_TIME_OUT_BIT = 2;
    localparam int unsigned STAT_EARLY_BIT = 3;
    localparam int unsigned STAT_ANSWER_ERR_BIT = 4;
    localparam int unsigned STAT_INDEX_LSB = 5;
    localparam int unsigned STAT_FAIL_LSB = 8;

    // ------------------------------------------------------------
    // Interrupt event bit positions
    // ------------------------------------------------------------
    localparam int unsigned EVT_GOOD_BIT = 0;
    localparam int unsigned EVT_BAD_BIT = 1;
    localparam int unsigned EVT_TIMEOUT_BIT = 2;
    localparam int unsigned EVT_CFG_BIT = 3;

    // ------------------------------------------------------------
    // Reset values, fail count limit and Markov seed
    // ------------------------------------------------------------
    localparam logic [1:0] REPLY_INDEX_START = 2'h3;
    localparam logic [2:0] FAIL_COUNT_RESET = 3'h0;
    localparam logic [2:0] FAIL_COUNT_MAX = 3'h7;
    localparam logic [7:0] WINDOW_DURATION_RESET = 8'h00;
    localparam logic [1:0] FEEDBACK_RESET = 2'h0;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    localparam logic [3:0] QUESTION_RESET = 4'h0;
    localparam logic [3:0] MARKOV_SEED = 4'h1;

    // ------------------------------------------------------------
    // Reference reply bytes, indexed by question
    // ------------------------------------------------------------
    localparam logic [15:0][7:0] FIRST_REPLY_TABLE = {
        8'h01, 8'h4E, 8'h17, 8'h58, 8'h8B, 8'hC4, 8'h9D, 8'hD2,
        8'h2C, 8'h63, 8'h3A, 8'h75, 8'hA6, 8'hE9, 8'hB0, 8'hFF
    };
    // Indexed by reply index: 3 first byte, 0 final byte
    localparam logic [3:0][7:0] REPLY_XOR_TABLE = {8'h00, 8'hF0, 8'h0F, 8'hFF};

endpackage : qa_watchdog_pkg

//--- rtl/qa_reset_sync.sv
// Two-stage release synchroniser for the active-low reset.
// Assumes the raw reset may rise at any moment relative to clk_in.
`timescale 1ns/10ps
`default_nettype none

module qa_reset_sync (
    input wire logic clk_in,
    input wire logic rstn_in,
    output logic rstn_sync_out
);

    typedef struct packed {
        logic [1:0] stage;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    always_comb begin
        state_next = state_reg;
        state_next.stage = {state_reg.stage[0], 1'b1};
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rstn_sync_out = state_reg.stage[1];

endmodule : qa_reset_sync

`default_nettype wire

//--- rtl/qa_reference_gen.sv
// Question generation and reference reply byte for the answer checker.
// Assumes advance_in is a one-cycle pulse after each good sequence.
`timescale 1ns/10ps
`default_nettype none

module qa_reference_gen
    import qa_watchdog_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic advance_in,
    input wire logic [1:0] reply_index_in,
    output logic [3:0] question_out,
    output logic [7:0] reference_byte_out
);

    typedef struct packed {
        logic [3:0] counter;
        logic [3:0] markov;
    } ref_state_t;

    ref_state_t state_reg;
    ref_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (advance_in) begin
            state_next.counter = state_reg.counter + 4'h1;
            // Markov chain steps when the counter wraps to zero
            if (state_reg.counter == 4'hF) begin
                if (state_reg.markov == 4'h0) begin
                    // Leaves the all-zero point, which the LFSR would never exit
                    state_next.markov = MARKOV_SEED;
                end else begin
                    state_next.markov = {state_reg.markov[2:0], state_reg.markov[3] ^ state_reg.markov[2]};
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= {QUESTION_RESET, QUESTION_RESET};
        end else begin
            state_reg <= state_next;
        end
    end

    assign question_out = state_reg.counter ^ state_reg.markov;
    // First byte from table, later bytes by fixed masks
    assign reference_byte_out = FIRST_REPLY_TABLE[question_out] ^ REPLY_XOR_TABLE[reply_index_in];

endmodule : qa_reference_gen

`default_nettype wire

//--- verif/qa_watchdog_assertions.sv
// Port checker for the watchdog answer checker.
// Assumes the bench is the only APB master on the port.
`timescale 1ns/10ps
`default_nettype none

module qa_watchdog_checker
    import qa_watchdog_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic pready_out,
    input wire logic close_window_in,
    input wire logic timeout_in,
    input wire logic sequence_start_out,
    input wire logic [2:0] fail_count_out
);
    // ----------------------------------------
    // Commit strobes
    // ----------------------------------------
    logic hit;
    logic reply_hit;
    logic cfg_hit;
    assign hit = psel_in && penable_in && pready_out && pwrite_in;
    assign reply_hit = hit && paddr_in == ADDR_REPLY_BYTE;
    assign cfg_hit = hit && (paddr_in == ADDR_OPEN_WINDOW || paddr_in == ADDR_CLOSE_WINDOW);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    chk_tmo_restart: assert property (timeout_in |=> sequence_start_out)
        else $error("No restart after time-out");
    chk_tmo_count: assert property (timeout_in && fail_count_out != 3'h7
        |=> fail_count_out == $past(fail_count_out) + 3'h1) else $error("Time-out did not count");
    chk_cfg_restart: assert property (cfg_hit |=> sequence_start_out)
        else $error("No restart after duration write");
    chk_cfg_count: assert property (cfg_hit && fail_count_out != 3'h7
        |=> fail_count_out == $past(fail_count_out) + 3'h1) else $error("Duration write did not count");
    chk_good_window: assert property (fail_count_out < $past(fail_count_out)
        |-> $past(reply_hit && close_window_in)) else $error("Count fell without a closing reply");
    chk_good_step: assert property (fail_count_out < $past(fail_count_out)
        |-> fail_count_out == $past(fail_count_out) - 3'h1) else $error("Count fell by more than one");
    chk_fail_rise: assert property (fail_count_out > $past(fail_count_out)
        |-> fail_count_out == $past(fail_count_out) + 3'h1 && sequence_start_out) else $error("Bad count rise");
    chk_start_cause: assert property (sequence_start_out
        |-> $past(reply_hit || timeout_in || cfg_hit)) else $error("Restart without a cause");
    cover property (timeout_in);
    cover property (cfg_hit);
    cover property (fail_count_out < $past(fail_count_out));
endmodule : qa_watchdog_checker

bind qa_watchdog_answer_check qa_watchdog_checker u_chk (.clk_in(clk_in), .rstn_in(rstn_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pready_out(pready_out), .close_window_in(close_window_in), .timeout_in(timeout_in),
    .sequence_start_out(sequence_start_out), .fail_count_out(fail_count_out));

`default_nettype wire

//--- verif/qa_mcu_model.sv
// Safety microcontroller model: APB master plus window timer lines.
// Assumes tasks are entered just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none

module qa_mcu_model (
    input wire logic clk_in,
    input wire logic pready_in,
    input wire logic [31:0] prdata_in,
    input wire logic pslverr_in,
    output logic psel_out,
    output logic penable_out,
    output logic pwrite_out,
    output logic [7:0] paddr_out,
    output logic [31:0] pwdata_out,
    output logic close_window_out,
    output logic timeout_out
);
    initial begin
        {psel_out, penable_out, pwrite_out, paddr_out, pwdata_out} = '0;
        close_window_out = 1'b1;
        timeout_out = 1'b0;
    end
    // Request held until pready; an idle edge follows
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        psel_out <= 1'b1;
        penable_out <= 1'b0;
        pwrite_out <= w;
        paddr_out <= a;
        pwdata_out <= d;
        @(posedge clk_in);
        penable_out <= 1'b1;
        do @(posedge clk_in); while (pready_in !== 1'b1);
        r = prdata_in;
        e = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        @(posedge clk_in);
    endtask : xfer
    task automatic win(input logic v);
        close_window_out <= v;
    endtask : win
    task automatic pulse_timeout();
        timeout_out <= 1'b1;
        @(posedge clk_in);
        timeout_out <= 1'b0;
        @(posedge clk_in);
    endtask : pulse_timeout
endmodule : qa_mcu_model

`default_nettype wire

//--- verif/tb_qa_watchdog_answer_check.sv
// Self-checking bench for the watchdog answer checker.
// Assumes the design keeps one wait state on APB.
`timescale 1ns/10ps
`default_nettype none

module tb_qa_watchdog_answer_check;
    import qa_watchdog_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic lock = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, close_win, tmo, start, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] fail;
    logic err;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    int exp_fail = 0;
    logic [3:0] q_cur = 4'h0;
    logic [7:0] first_tab [16] = '{8'hFF, 8'hB0, 8'hE9, 8'hA6, 8'h75, 8'h3A, 8'h63, 8'h2C,
        8'hD2, 8'h9D, 8'hC4, 8'h8B, 8'h58, 8'h17, 8'h4E, 8'h01};
    logic [7:0] mask_tab [4] = '{8'h00, 8'hF0, 8'h0F, 8'hFF};

    qa_watchdog_answer_check u_dut (.clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
        .pslverr_out(pslverr), .close_window_in(close_win), .timeout_in(tmo), .config_lock_in(lock),
        .sequence_start_out(start), .fail_count_out(fail), .irq_out(irq));
    qa_mcu_model u_mcu (.clk_in(clk), .pready_in(pready), .prdata_in(prdata), .pslverr_in(pslverr),
        .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
        .close_window_out(close_win), .timeout_out(tmo));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            print_verdict();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, want, seen);
        end
    endtask : check
    task automatic rd_reg(input logic [7:0] a);
        u_mcu.xfer(1'b0, a, 32'h0, rd, err);
    endtask : rd_reg
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        u_mcu.xfer(1'b1, a, d, rd, err);
    endtask : wr_reg
    // Saturating fail count; flags: early, time-out, error, config
    task automatic chk_stat(input logic up, input logic [3:0] flags);
        exp_fail = up ? (exp_fail == 7 ? 7 : exp_fail + 1) : (exp_fail == 0 ? 0 : exp_fail - 1);
        rd_reg(ADDR_WATCHDOG_STATUS);
        check("status", {rd[10:8], rd[6:5], rd[3:0]}, {exp_fail[2:0], 2'h3, flags});
        check("fail port", {29'h0, fail}, exp_fail);
        rd_reg(ADDR_QUESTION_VALUE);
        check("question", rd, {28'h0, q_cur});
    endtask : chk_stat
    task automatic send(input logic [3:0] q, input int bad, input logic early, input int n);
        u_mcu.win(!early);
        for (int k = 0; k < n; k++) begin
            wr_reg(ADDR_REPLY_BYTE, {24'h0, first_tab[q] ^ mask_tab[k] ^ (k == bad ? 8'h01 : 8'h00)});
        end
    endtask : send

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_timeout(input logic wrong);
        wr_reg(ADDR_IRQ_MASK, wrong ? 32'h0 : 32'h4);
        send(q_cur, wrong ? 1 : 4, 1'b0, 3);
        u_mcu.pulse_timeout();
        chk_stat(1'b1, {2'b01, wrong, 1'b0});
        check("irq raised", {31'h0, irq}, {31'h0, !wrong});
        rd_reg(ADDR_IRQ_STATUS);
        check("irq status", rd, 32'h4);
        wr_reg(ADDR_IRQ_STATUS, 32'hF);
        @(posedge clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
    endtask : t_timeout
    task automatic t_good_all();
        for (int i = 0; i < 16; i++) begin
            send(i[3:0], 4, 1'b0, 4);
            q_cur = (i == 15) ? MARKOV_SEED : i[3:0] + 4'h1;
            chk_stat(1'b0, 4'h0);
        end
    endtask : t_good_all
    task automatic t_bad(input int bad, input logic early, input logic [3:0] flags);
        send(q_cur, bad, early, 4);
        chk_stat(1'b1, flags);
    endtask : t_bad
    task automatic t_cfg(input logic l, input logic [7:0] a);
        lock <= l;
        send(q_cur, 4, 1'b0, 1);
        wr_reg(a, 32'h5A);
        chk_stat(1'b1, 4'h1);
        rd_reg(a);
        check("duration", rd, l ? 32'h0 : 32'h5A);
    endtask : t_cfg

    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        rd_reg(8'h20);
        check("unmapped", {rd[30:0], err}, 32'h1);
        t_timeout(1'b0);
        t_timeout(1'b1);
        t_good_all();
        rd_reg(ADDR_QUESTION_VALUE);
        check("wrap question", rd, 32'h1);
        t_bad(4, 1'b1, 4'h8);
        t_bad(2, 1'b0, 4'h2);
        t_bad(0, 1'b1, 4'hA);
        t_cfg(1'b1, ADDR_OPEN_WINDOW);
        t_cfg(1'b0, ADDR_CLOSE_WINDOW);
        print_verdict();
    end
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
endmodule : tb_qa_watchdog_answer_check

`default_nettype wire
